//--- rtl/step_seq.sv
/*
  Indexing program step sequencer with AXI4-Lite access to the program table.
  Assumes host-side digital I/O arrives asynchronously on pins, a motion core
  supplies positioning/near/distribution flags and an error level, and a
  boot loader writes the saved table over AXI after power-up.
*/
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "step_seq_params.svh"
module step_seq
  import step_seq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        run_stop_pin,
  input  wire logic        program_reset_input,
  input  wire logic        mode1_pin,
  input  wire logic [4:0]  step_select_input,
  input  wire logic        positioning_done,
  input  wire logic        near_window,
  input  wire logic        distribution_done,
  input  wire logic        drive_error,
  input  wire logic [4:0]  region_flag,
  output logic [4:0]       program_output_line,
  output logic [7:0]       program_step_index,
  output logic [31:0]      active_accel,
  output logic [31:0]      active_decel,
  output logic             step_start,
  output logic             seq_operating
);

  // ========================================================================
  // Program table storage: ctrl, wait, loop, accel, decel per step
  logic [23:0] tbl_ctrl_r [`STEPS];
  logic [16:0] tbl_wait_r [`STEPS];
  logic [16:0] tbl_loop_r [`STEPS];
  logic [27:0] tbl_acc_r  [`STEPS];
  logic [27:0] tbl_dec_r  [`STEPS];
  logic [31:0] def_acc_r;
  logic [31:0] def_dec_r;
  logic [7:0]  loop_addr_r;

  // ========================================================================
  // Pin synchronisers: three stages, change accepted when 2nd and 3rd agree
  localparam int NPIN = 13;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] pin_r;
  assign pin_raw = {region_flag, step_select_input, mode1_pin,
                    program_reset_input, run_stop_pin};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NPIN; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          pin_r[i] <= s3_r[i];
        end
      end
    end
  end
  logic       run_q;
  logic       prst_q;
  logic       mode1_q;
  logic [4:0] sel_q;
  logic [4:0] zone_q;
  assign run_q   = pin_r[0];
  assign prst_q  = pin_r[1];
  assign mode1_q = pin_r[2];
  assign sel_q   = pin_r[7:3];
  assign zone_q  = pin_r[12:8];

  // ========================================================================
  // Free-running millisecond tick
  logic [16:0] ms_cnt_r;
  logic        ms_tick;
  assign ms_tick = (ms_cnt_r == 17'(`MS_TICK_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_tick ? 17'h0 : ms_cnt_r + 17'h1;
    end
  end

  // ========================================================================
  // Sequencer
  seq_state_e  state_r;
  step_phase_e phase_r;
  logic [7:0]  step_r;
  logic [16:0] runs_r;
  logic [16:0] wait_r;
  logic [3:0]  ev_r;
  logic [16:0] evwait_r;
  logic        run_d_r;
  logic        first_r;
  logic        err_stop_r;
  logic [23:0] cur_ctrl;
  logic [3:0]  ev_code;
  logic [16:0] ev_wait;
  logic        ev_hit;
  logic        run_rise;
  logic        step_over;

  assign cur_ctrl = tbl_ctrl_r[step_r];
  assign run_rise = run_q & ~run_d_r;

  // Resolve inherited end condition
  always_comb begin
    ev_code = cur_ctrl[`F_EV_MSB:`F_EV_LSB];
    ev_wait = tbl_wait_r[step_r];
    if (ev_code == `EV_INHERIT) begin
      ev_code = ev_r;
      ev_wait = evwait_r;
    end
  end

  // Condition decode
  always_comb begin
    case (ev_code)
      `EV_POSITIONING_DONE: ev_hit = positioning_done;
      `EV_NEAR: ev_hit = near_window;
      `EV_DEN:  ev_hit = distribution_done;
      default: begin
        ev_hit = (ev_code >= `EV_SEL0) && (ev_code < 4'(`EV_SEL0 + 5))
               && sel_q[3'(ev_code - `EV_SEL0)];
      end
    endcase
  end

  // Pattern decode per line
  function automatic logic pat_bit(input logic [1:0] code,
                                   input logic       prev,
                                   input logic       zone);
    case (code)
      `PAT_ON:   pat_bit = 1'b1;
      `PAT_OFF:  pat_bit = 1'b0;
      `PAT_HOLD: pat_bit = prev;
      default:   pat_bit = zone;
    endcase
  endfunction : pat_bit

  assign step_over = (runs_r + 17'h1 >= tbl_loop_r[step_r]);

  // Run/stop edge memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= run_q;
    end
  end

  // Main state and step control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ST_CANCELED;
      phase_r    <= PH_START;
      step_r     <= 8'h0;
      runs_r     <= '0;
      wait_r     <= '0;
      ev_r       <= `EV_POSITIONING_DONE;
      evwait_r   <= '0;
      first_r    <= 1'b0;
      err_stop_r <= 1'b0;
      step_start <= 1'b0;
      program_output_line <= '0;
      active_accel <= `DEF_RATE_RST;
      active_decel <= `DEF_RATE_RST;
    end else begin
      step_start <= 1'b0;
      case (state_r)
        ST_CANCELED: begin
          if (run_rise && !mode1_q) begin
            state_r <= ST_OPERATING;
            step_r  <= {3'h0, sel_q};
            runs_r  <= '0;
            first_r <= 1'b1;
            phase_r <= PH_START;
          end
        end
        ST_OPERATING: begin
          if (drive_error) begin
            state_r    <= ST_STOPPED;
            err_stop_r <= 1'b1;
          end else if (!run_q) begin
            state_r <= ST_STOPPED;
          end else begin
            case (phase_r)
              PH_START: begin
                for (int i = 0; i < 5; i++) begin
                  program_output_line[i] <= pat_bit(
                    cur_ctrl[2*i +: 2], program_output_line[i], zone_q[i]);
                end
                if (first_r && tbl_acc_r[step_r] == 28'h0) begin
                  active_accel <= def_acc_r;
                end else if (tbl_acc_r[step_r] != 28'h0) begin
                  active_accel <= 32'(tbl_acc_r[step_r]);
                end
                if (first_r && tbl_dec_r[step_r] == 28'h0) begin
                  active_decel <= def_dec_r;
                end else if (tbl_dec_r[step_r] != 28'h0) begin
                  active_decel <= 32'(tbl_dec_r[step_r]);
                end
                first_r    <= 1'b0;
                ev_r       <= ev_code;
                evwait_r   <= ev_wait;
                step_start <= 1'b1;
                phase_r    <= PH_WAIT;
              end
              PH_WAIT: begin
                if (ev_hit) begin
                  wait_r  <= ev_wait;
                  phase_r <= PH_DELAY;
                end
              end
              PH_DELAY: begin
                if (wait_r == 17'h0) begin
                  phase_r <= PH_DONE;
                end else if (ms_tick) begin
                  wait_r <= wait_r - 17'h1;
                end
              end
              PH_DONE: begin
                phase_r <= PH_START;
                if (!step_over) begin
                  runs_r <= runs_r + 17'h1;
                end else if (cur_ctrl[`F_END_BIT]) begin
                  state_r <= ST_CANCELED;
                end else begin
                  runs_r <= '0;
                  step_r <= cur_ctrl[`F_NEXT_MSB:`F_NEXT_LSB];
                end
              end
              default: phase_r <= PH_START;
            endcase
          end
        end
        ST_STOPPED: begin
          if (prst_q) begin
            state_r    <= ST_CANCELED;
            err_stop_r <= 1'b0;
          end else if (run_rise) begin
            state_r    <= ST_OPERATING;
            err_stop_r <= 1'b0;
            // Error restart skips ahead to PH_DONE, plain pause resumes the phase it left
            phase_r    <= err_stop_r ? PH_DONE : phase_r;
          end
        end
        default: state_r <= ST_CANCELED;
      endcase
    end
  end

  // Status to pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_step_index <= '0;
      seq_operating      <= 1'b0;
    end else begin
      program_step_index <= step_r;
      seq_operating      <= (state_r == ST_OPERATING);
    end
  end

  // ========================================================================
  // AXI4-Lite slave; write taken once address and data both present
  logic wr_go;
  logic wr_tbl;
  logic [7:0] wr_idx;
  logic [1:0] wr_word;
  assign wr_go   = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign wr_tbl  = s_axi_awaddr >= `A_TBL_BASE;
  assign wr_idx  = 8'(s_axi_awaddr[11:4] - 8'h40);
  assign wr_word = s_axi_awaddr[3:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (wr_go && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (wr_tbl || s_axi_awaddr <= `A_LOOP_DATA)
                         ? `OKAY : `SLVERR;
      end
    end
  end

  // Register and table storage; loaded at boot from the saved copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      def_acc_r   <= `DEF_RATE_RST;
      def_dec_r   <= `DEF_RATE_RST;
      loop_addr_r <= '0;
    end else if (wr_go && !s_axi_awready && s_axi_wstrb == 4'hf) begin
      if (wr_tbl) begin
        case (wr_word)
          2'h0: tbl_acc_r[wr_idx]  <= s_axi_wdata[27:0];
          2'h1: tbl_dec_r[wr_idx]  <= s_axi_wdata[27:0];
          2'h2: tbl_ctrl_r[wr_idx] <= s_axi_wdata[23:0];
          default: tbl_wait_r[wr_idx] <= s_axi_wdata[16:0];
        endcase
      end else begin
        case (s_axi_awaddr)
          `A_DEF_ACC:   def_acc_r   <= s_axi_wdata;
          `A_DEF_DEC:   def_dec_r   <= s_axi_wdata;
          `A_LOOP_ADDR: loop_addr_r <= s_axi_wdata[7:0];
          `A_LOOP_DATA: tbl_loop_r[loop_addr_r] <= s_axi_wdata[16:0];
          default: ;
        endcase
      end
    end
  end

  // Read channel, data valid in the same cycle the address is taken
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      `A_CTRL:      rd_mux = {31'h0, err_stop_r};
      `A_STATUS:    rd_mux = {22'h0, step_r, state_r};
      `A_DEF_ACC:   rd_mux = def_acc_r;
      `A_DEF_DEC:   rd_mux = def_dec_r;
      `A_LOOP_ADDR: rd_mux = {24'h0, loop_addr_r};
      `A_LOOP_DATA: rd_mux = {15'h0, tbl_loop_r[loop_addr_r]};
      `A_ACT_ACC:   rd_mux = active_accel;
      `A_ACT_DEC:   rd_mux = active_decel;
      default:      rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= (s_axi_araddr <= `A_ACT_DEC) ? `OKAY : `SLVERR;
      end
    end
  end

endmodule : step_seq

//--- rtl/step_seq_params.svh
/*
  Constants for the indexing step sequencer: table field positions, codes,
  ranges and timing counts.
  Assumes a 125 MHz system clock and an AXI4-Lite register port.
*/
`ifndef STEP_SEQ_PARAMS_SVH
`define STEP_SEQ_PARAMS_SVH

// ==========================================================================
// Timing
`define CLK_HZ          125000000
`define MS_TICK_NS      1000000
`define MS_TICK_CYC     ((`MS_TICK_NS * 64'd125) / 64'd1000)
`define SEL_HOLD_MS     4
`define WAIT_MAX_MS     99999
`define LOOP_MAX        99999
`define RATE_MAX        199999999
`define RATE_MIN        1

// ==========================================================================
// Table geometry and entry layout (one entry is four 32-bit words)
`define STEPS           256
`define W_ACC           0
`define W_DEC           1
`define W_CTRL          2
`define W_TIME          3
// Control word fields
`define F_PAT_LSB       0
`define F_PAT_MSB       9
`define F_EV_LSB        10
`define F_EV_MSB        13
`define F_NEXT_LSB      14
`define F_NEXT_MSB      21
`define F_END_BIT       22
`define F_NOMOVE_BIT    23
// Time word: [16:0] wait ms; loop counts go through the loop registers
`define F_WAIT_LSB      0
`define F_WAIT_MSB      16
// Pattern digit codes (two bits per line)
`define PAT_OFF         2'h0
`define PAT_ON          2'h1
`define PAT_HOLD        2'h2
`define PAT_ZONE        2'h3
// End condition codes
`define EV_POSITIONING_DONE         4'h0
`define EV_NEAR         4'h1
`define EV_DEN          4'h2
`define EV_SEL0         4'h3
`define EV_INHERIT      4'hf

// ==========================================================================
// Register map (byte addresses)
`define A_CTRL          12'h000
`define A_STATUS        12'h004
`define A_DEF_ACC       12'h008
`define A_DEF_DEC       12'h00c
`define A_LOOP_ADDR     12'h010
`define A_LOOP_DATA     12'h014
`define A_ACT_ACC       12'h018
`define A_ACT_DEC       12'h01c
`define A_TBL_BASE      12'h400
`define DEF_RATE_RST    32'h0000_03e8
`define OKAY            2'h0
`define SLVERR          2'h2

`endif

//--- rtl/step_seq_pkg.sv
/*
  Types for the indexing step sequencer.
  Assumes step_seq_params.svh for numeric constants other than the state and phase codes set here.
*/
package step_seq_pkg;
  // Gray-coded along canceled -> operating -> stopped
  typedef enum logic [1:0] {
    ST_CANCELED  = 2'h0,
    ST_OPERATING = 2'h1,
    ST_STOPPED   = 2'h3
  } seq_state_e;
  typedef enum logic [1:0] {
    PH_START = 2'h0,
    PH_WAIT  = 2'h1,
    PH_DELAY = 2'h3,
    PH_DONE  = 2'h2
  } step_phase_e;
endpackage : step_seq_pkg

//--- test/step_seq_sva.sv
/*
  Checker for step_seq: AXI answer timing, step pulse and state rules.
  Assumes one aclk domain; bound to every step_seq at the foot of the file.
*/
`timescale 1ns/10ps
`include "step_seq_params.svh"
module step_seq_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        drive_error,
  input wire logic [4:0]  program_output_line,
  input wire logic [31:0] active_accel,
  input wire logic        step_start,
  input wire logic        seq_operating
);
  // ==========================================================================
  // Bus answers
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
    else $error("write not answered next cycle");
  a_read_answer: assert property (
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered next cycle");
  a_ready_pair: assert property (
    s_axi_awready |-> s_axi_wready && s_axi_bvalid)
    else $error("write channels answered apart");
  a_resp_code: assert property (
    s_axi_bvalid |-> s_axi_bresp == `OKAY || s_axi_bresp == `SLVERR)
    else $error("illegal write response");

  // ==========================================================================
  // Sequencer
  a_start_single: assert property (
    step_start |=> !step_start)
    else $error("step start longer than one cycle");
  a_start_operating: assert property (
    step_start |-> ##[0:1] seq_operating)
    else $error("step started while not operating");
  a_error_stop: assert property (
    seq_operating && drive_error |-> ##[1:4] !seq_operating)
    else $error("error did not stop operation");
  // Reset check must not be masked by the default disable
  a_reset_clear: assert property (disable iff (1'b0)
    !aresetn |=> program_output_line == 5'h00 && !seq_operating
    && !step_start && active_accel == `DEF_RATE_RST)
    else $error("outputs not cleared by reset");

  c_step: cover property (step_start);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `SLVERR);
  c_stop: cover property ($fell(seq_operating));
endmodule : step_seq_chk

bind step_seq step_seq_chk u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .drive_error, .program_output_line,
  .active_accel, .step_start, .seq_operating
);

//--- test/motion_flags_model.sv
/*
  Motion-side model: answers each step start with completion flags.
  Assumes step_start comes from the sequencer on the same aclk.
*/
`timescale 1ns/10ps
module motion_flags_model (
  input  wire logic       aclk,
  input  wire logic       step_start,
  input  wire logic [2:0] flag_mask,
  input  wire logic [7:0] settle_dly,
  output logic            positioning_done,
  output logic            near_window,
  output logic            distribution_done
);
  logic [7:0] cnt_r = 8'h00;

  // Settle counter restarts on every step; flags drop in the start cycle
  // itself so a stale done can never end the new step
  always_ff @(posedge aclk) begin
    if (step_start) cnt_r <= settle_dly;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
  end
  assign {distribution_done, near_window, positioning_done} =
    (cnt_r == 8'h00 && !step_start) ? flag_mask : 3'h0;
endmodule : motion_flags_model

//--- test/step_seq_tb_top.sv
/*
  Self-checking bench for step_seq: table load, step flow and states.
  Assumes the motion model answers step starts; waits of 0 ms only.
*/
`timescale 1ns/10ps
`include "step_seq_params.svh"
module step_seq_tb_top
  import step_seq_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, run_stop_pin = 1'b0, mode1_pin = 1'b0;
  logic program_reset_input = 1'b0, drive_error = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [4:0]  step_select_input = 5'h00, region_flag = 5'h00;
  logic [2:0]  flag_mask = 3'h7;
  logic [7:0]  settle_dly = 8'h10;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, positioning_done, near_window, distribution_done;
  logic step_start, seq_operating;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, active_accel, active_decel;
  logic [4:0]  program_output_line;
  logic [7:0]  program_step_index;
  int          err_count = 0, n_tests = 0, cyc = 0;

  step_seq DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_stop_pin,
    .program_reset_input, .mode1_pin, .step_select_input,
    .positioning_done, .near_window, .distribution_done, .drive_error,
    .region_flag, .program_output_line, .program_step_index,
    .active_accel, .active_decel, .step_start, .seq_operating);
  motion_flags_model u_motion (.aclk, .step_start, .flag_mask,
    .settle_dly, .positioning_done, .near_window, .distribution_done);

  // ==========================================================================
  // Clock and hang guard; the whole run needs a few thousand cycles
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ==========================================================================
  // AXI4-Lite master; each task starts on a fresh edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd

  // ==========================================================================
  // Table helpers and expectations
  function automatic logic [31:0] ctl(logic [9:0] p, logic [3:0] e,
                                      logic [7:0] nx, logic en);
    return {9'h000, en, nx, e, p};
  endfunction : ctl

  function automatic logic [4:0] pexp(logic [9:0] p, logic [4:0] prev,
                                      logic [4:0] z);
    for (int i = 0; i < 5; i++) begin
      case (p[2*i +: 2])
        `PAT_ON:   pexp[i] = 1'b1;
        `PAT_OFF:  pexp[i] = 1'b0;
        `PAT_HOLD: pexp[i] = prev[i];
        default:   pexp[i] = z[i];
      endcase
    end
  endfunction : pexp

  // Loaded only while the sequencer is idle
  task automatic put_step(input int s, input logic [31:0] ac, dc, ct, lp);
    logic [11:0] b;
    b = `A_TBL_BASE + 12'(s * 16);
    wr(b, ac, `OKAY);
    wr(b + 12'h004, dc, `OKAY);
    wr(b + 12'h008, ct, `OKAY);
    wr(b + 12'h00c, 32'h0, `OKAY);
    wr(`A_LOOP_ADDR, 32'(s), `OKAY);
    wr(`A_LOOP_DATA, lp, `OKAY);
  endtask : put_step

  // Start step presented well before run and left alone afterwards
  task automatic go(input int s);
    step_select_input <= 5'(s);
    repeat (10) @(posedge aclk);
    run_stop_pin <= 1'b1;
  endtask : go

  task automatic wait_start();
    int n;
    n = 0;
    while (step_start !== 1'b1 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(step_start), 32'h1);
    repeat (2) @(posedge aclk);
  endtask : wait_start

  task automatic wait_idle();
    int n;
    n = 0;
    while (seq_operating !== 1'b0 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(seq_operating), 32'h0);
  endtask : wait_idle

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] d, ra, rb, a1;
    logic [9:0]  p0, p1;
    logic [4:0]  eo;
    int          s0;
    void'($urandom(73469));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(active_accel, `DEF_RATE_RST);
    rd(`A_DEF_ACC, `OKAY, d);
    chk(d, `DEF_RATE_RST);
    ra = 32'($urandom_range(`RATE_MAX, `RATE_MIN));
    rb = 32'($urandom_range(`RATE_MAX, `RATE_MIN));
    wr(`A_DEF_ACC, ra, `OKAY);
    wr(`A_DEF_DEC, rb, `OKAY);
    rd(`A_DEF_DEC, `OKAY, d);
    chk(d, rb);
    rd(12'h020, `SLVERR, d);
    rd(`A_TBL_BASE, `SLVERR, d);
    wr(12'h024, 32'h0, `SLVERR);
    $display("test registers done");

    // Chain: default rates, then a step with inherited end condition repeated three times
    s0 = $urandom_range(30, 0);
    d = $urandom;
    for (int i = 0; i < 5; i++) p0[2*i +: 2] = {1'b0, d[i]};
    p1 = 10'($urandom);
    a1 = 32'($urandom_range(`RATE_MAX, `RATE_MIN));
    region_flag <= 5'($urandom);
    settle_dly <= 8'($urandom_range(40, 8));
    put_step(s0, 32'h0, 32'h0, ctl(p0, `EV_POSITIONING_DONE, 8'(s0 + 1), 1'b0), 32'h1);
    put_step(s0 + 1, a1, a1, ctl(p1, `EV_INHERIT, 8'h00, 1'b1), 32'h3);
    go(s0);
    wait_start();
    chk(32'(program_step_index), 32'(s0));
    chk(active_accel, ra);
    chk(active_decel, rb);
    eo = pexp(p0, 5'h00, region_flag);
    chk(32'(program_output_line), 32'(eo));
    for (int k = 0; k < 3; k++) begin
      wait_start();
      eo = pexp(p1, eo, region_flag);
      chk(32'(program_step_index), 32'(s0 + 1));
      chk(32'(program_output_line), 32'(eo));
      chk(active_accel, a1);
    end
    wait_idle();
    chk(32'(step_start), 32'h0);
    run_stop_pin <= 1'b0;
    $display("test chain done");

    // Each end condition: others present first, then the right one
    for (int e = 0; e < 8; e++) begin
      put_step(0, 32'h1, 32'h1, ctl(10'h155, 4'(e), 8'h00, 1'b1), 32'h1);
      flag_mask <= (e < 3) ? (3'h7 & ~(3'h1 << e)) : 3'h7;
      go(0);
      wait_start();
      repeat (60) @(posedge aclk);
      chk(32'(seq_operating), 32'h1);
      if (e < 3) flag_mask <= 3'h7;
      else step_select_input <= 5'h01 << (e - 3);
      wait_idle();
      run_stop_pin <= 1'b0;
      step_select_input <= 5'h00;
    end
    $display("test events done");

    // Stop, resume, program reset, error skip
    put_step(1, 32'h1, 32'h1, ctl(10'h000, `EV_POSITIONING_DONE, 8'h02, 1'b0), 32'h1);
    put_step(2, 32'h1, 32'h1, ctl(10'h3ff, `EV_POSITIONING_DONE, 8'h00, 1'b1)
             | (32'h1 << `F_NOMOVE_BIT), 32'h1);
    flag_mask <= 3'h0;
    go(1);
    wait_start();
    run_stop_pin <= 1'b0;
    repeat (12) @(posedge aclk);
    rd(`A_STATUS, `OKAY, d);
    chk(32'(d[1:0]), 32'(ST_STOPPED));
    run_stop_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    rd(`A_STATUS, `OKAY, d);
    chk(32'(d[1:0]), 32'(ST_OPERATING));
    run_stop_pin <= 1'b0;
    repeat (12) @(posedge aclk);
    program_reset_input <= 1'b1;
    repeat (12) @(posedge aclk);
    rd(`A_STATUS, `OKAY, d);
    chk(32'(d[1:0]), 32'(ST_CANCELED));
    program_reset_input <= 1'b0;
    go(1);
    wait_start();
    drive_error <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(seq_operating), 32'h0);
    drive_error <= 1'b0;
    run_stop_pin <= 1'b0;
    repeat (12) @(posedge aclk);
    flag_mask <= 3'h7;
    run_stop_pin <= 1'b1;
    wait_start();
    chk(32'(program_step_index), 32'h2);
    chk(32'(program_output_line), 32'(region_flag));
    wait_idle();
    run_stop_pin <= 1'b0;

    // Mode 1 never starts the table
    mode1_pin <= 1'b1;
    go(0);
    repeat (60) @(posedge aclk);
    chk(32'(seq_operating), 32'h0);
    $display("test states done");
    test_done();
  end
endmodule : step_seq_tb_top
